// file: shared/ebp_pkg.sv
package ebp_pkg;

  // Word layout on the fabric port
  localparam int DATA_W     = 256;
  localparam int WORD_W     = 293;
  localparam int MOD_LSB    = 256;
  localparam int MOD_W      = 5;
  localparam int SB_LSB     = 261;
  localparam int SB_W       = 30;
  localparam int WORD_BYTES = 32;

  // Unit identifier and tied reset level
  localparam logic [3:0] UNIT_ID          = 4'hF;
  localparam logic       FABRIC_RST_LEVEL = 1'h0;

  // Transmit flag positions within the sideband
  localparam int FLG_TAG_LSB = 0;
  localparam int FLG_TAG_W   = 4;
  localparam int FLG_UPD     = 4;
  localparam int FLG_PEER    = 5;
  localparam int FLG_UDP     = 6;
  localparam int FLG_OFF_LSB = 7;
  localparam int FLG_OFF_W   = 8;
  localparam int FLG_TS64    = 15;
  localparam int FLG_DELTA   = 16;
  localparam int FLG_EVENT   = 17;
  localparam int FLG_ERR     = 18;
  localparam int FLG_INS     = 19;
  localparam int FLG_INV     = 20;
  localparam int FLG_OVR     = 21;
  localparam int FLG_CLS_A   = 22;
  localparam int FLG_CLS_B   = 23;

  // Timestamp counter: nanosecond ticks of a 1 GHz reference
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TS_TICK_NS    = 1;
  localparam logic [63:0] TS_STEP       = 64'(CLK_PERIOD_NS / TS_TICK_NS);

  // Frame check sequence
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_ERR_BIT = 32'h00000001;
  localparam logic [7:0]  BYTE_ERR    = 8'h01;
  localparam logic [6:0]  FCS_BYTES   = 7'h04;
  localparam logic [6:0]  UDP_BYTES   = 7'h02;
  localparam int          FIELD_BYTES = 8;

  // Register map
  localparam int         APB_ADDR_W  = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STAT    = 8'h04;
  localparam logic [7:0] REG_PEER    = 8'h08;
  localparam logic [7:0] REG_TXTAG   = 8'h0C;
  localparam logic [7:0] REG_TXCNT   = 8'h10;
  localparam logic [7:0] REG_RXCNT   = 8'h14;
  localparam logic [7:0] REG_TIME    = 8'h18;
  localparam int         CTRL_TX_EN  = 0;
  localparam int         CTRL_RX_EN  = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h3;
  localparam int         STAT_DESTER = 2;

  typedef enum logic [0:0] {
    ebp_st_run   = 1'b0,
    ebp_st_flush = 1'b1
  } ebp_tx_state_type;

endpackage

// file: rtl/ebp_stage.sv
`timescale 1ns/1ns
module ebp_stage #(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Upstream side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Downstream side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // Refills in the cycle it drains, so a stalled sink stalls the source
  assign in_ready = !out_valid || out_ready;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (in_ready)
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_data <= in_data;
    end
  end

endmodule

// file: rtl/ebp_port.sv
// Summary of operation
// R1 - All transfers sampled on the port clock
// R2 - Async low reset clears port logic only
// R3 - Fabric reset output held low always
// R4 - tx_ready high when a word is accepted
// R5 - Fabric drives destination id all ones
// R6 - Fabric marks first and last words
// R7 - Word holds data, byte count, sideband
// R8 - Receive valid with each word, fabric ready
// R9 - Receive source id always all ones
// R10 - Receive sideband: timestamp first, flags after
// R11 - Start word sideband carries a timestamp
// R12 - Receive timestamp from free nanosecond counter
// R13 - Event, class A, class B flag bits
// R14 - Forced error yields bad frame check
// R15 - Insert appends check, optionally inverted
// R16 - Override recomputes and overwrites existing check
// R17 - Frame tag reported once frame sent
// R18 - Bit 4 enables one-step field update
// R19 - Bit 5 adds configured peer delay
// R20 - Bit 6 corrects checksum in trailer bytes
// R21 - Bits 14..7 give field byte offset
// R22 - Bit 15 overwrites 8-byte field with time
// R23 - Bit 16 adds delta to correction field
// R24 - Word moves only when valid and ready
`timescale 1ns/1ns
module ebp_port
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset_n,
  output logic               fabric_reset_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Fabric transmit
  input  wire logic          tx_valid,
  output logic               tx_ready,
  input  wire logic [3:0]    tx_dest,
  input  wire logic          tx_sop,
  input  wire logic          tx_eop,
  input  wire logic [292:0]  tx_data,
  input  wire logic [47:0]   tx_corr_delta,
  output logic               tx_status_valid,
  output logic      [3:0]    tx_status_tag,
  // Fabric receive
  output logic               rx_valid,
  input  wire logic          rx_ready,
  output logic      [3:0]    rx_src,
  output logic               rx_sop,
  output logic               rx_eop,
  output logic      [292:0]  rx_data,
  // MAC transmit side
  output logic               line_tx_valid,
  input  wire logic          line_tx_ready,
  output logic      [255:0]  line_tx_data,
  output logic      [4:0]    line_tx_mod,
  output logic               line_tx_sop,
  output logic               line_tx_eop,
  output logic               line_tx_fcs_append,
  output logic      [31:0]   line_tx_fcs,
  output logic               line_tx_event,
  output logic               line_tx_class_a,
  output logic               line_tx_class_b,
  // MAC receive side
  input  wire logic          line_rx_valid,
  output logic               line_rx_ready,
  input  wire logic [255:0]  line_rx_data,
  input  wire logic [4:0]    line_rx_mod,
  input  wire logic          line_rx_sop,
  input  wire logic          line_rx_eop,
  input  wire logic [29:0]   line_rx_flags
);

  localparam int TXP_W = 303;
  localparam int RXP_W = 293;

  ebp_pkg::ebp_tx_state_type st_q;
  logic [1:0]   ctrl_q;
  logic [31:0]  peer_q;
  logic         dest_err_q;
  logic [31:0]  tx_cnt_q;
  logic [31:0]  rx_cnt_q;
  logic [63:0]  now_q;
  logic [29:0]  now_lo;
  logic [255:0] hold_q;
  logic         hold_v_q;
  logic         hold_sop_q;
  logic         hold_eop_q;
  logic [4:0]   hold_mod_q;
  logic         hold_app_q;
  logic [31:0]  hold_fcs_q;
  logic [2:0]   hold_cls_q;
  logic [3:0]   hold_tag_q;
  logic [15:0]  wpos_q;
  logic [31:0]  crc_q;
  logic         done_q;
  logic [29:0]  ts_in_q;
  logic         udp_pend_q;
  logic [15:0]  udp_adj_q;
  logic         acc;
  logic [29:0]  f;
  logic [6:0]   nb;
  logic [6:0]   end_i;
  logic [6:0]   dend;
  logic [6:0]   idx;
  logic [16:0]  idx_x;
  logic         hit;
  logic         ins;
  logic         ovr;
  logic         pend;
  logic [63:0]  oldf;
  logic [63:0]  newf;
  logic [47:0]  corr_sum;
  logic [15:0]  adj;
  logic [15:0]  udp_v;
  logic [31:0]  crc_next;
  logic [31:0]  fcs_good;
  logic [31:0]  fcs_out;
  logic [511:0] w0;
  logic [511:0] w1;
  logic [511:0] w2;
  logic [511:0] w3;
  logic         stg_in_valid;
  logic         stg_in_ready;
  logic [3:0]   line_tx_tag;
  logic         rx_in_ready;
  logic         apb_hit;
  logic [31:0]  rd_val;
  logic         apb_wr;

  function automatic logic [31:0] crc_fold(input logic [31:0] c, input logic [511:0] w,
                                           input logic [6:0] lo, input logic [6:0] hi);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 64; i++)
      if (7'(i) >= lo && 7'(i) < hi)
      begin
        r = r ^ {24'h000000, w[i*8 +: 8]};
        for (int b = 0; b < 8; b++)
          r = r[0] ? ((r >> 1) ^ ebp_pkg::CRC_POLY) : (r >> 1);
      end
    return r;
  endfunction

  // Most significant byte sits first in the frame
  function automatic logic [63:0] get_field(input logic [511:0] w, input logic [6:0] i);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < ebp_pkg::FIELD_BYTES; k++)
      r[63-8*k -: 8] = w[(int'(i)+k)*8 +: 8];
    return r;
  endfunction

  function automatic logic [511:0] put_field(input logic [511:0] w, input logic [6:0] i, input logic [63:0] v);
    logic [511:0] r;
    r = w;
    for (int k = 0; k < ebp_pkg::FIELD_BYTES; k++)
      r[(int'(i)+k)*8 +: 8] = v[63-8*k -: 8];
    return r;
  endfunction

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  function automatic logic [15:0] oc_sum3(input logic [63:0] v);
    return oc_add(oc_add(v[63:48], v[47:32]), v[31:16]);
  endfunction

  assign fabric_reset_n = ebp_pkg::FABRIC_RST_LEVEL; // R3
  assign rx_src         = ebp_pkg::UNIT_ID;          // R9
  assign now_lo         = now_q[29:0];

  // Nanosecond counter stepped by the 1 GHz tick count per clock
  always_ff @(posedge clock or negedge reset_n) // R1
  begin
    if (!reset_n)
      now_q <= '0;
    else
      now_q <= now_q + ebp_pkg::TS_STEP; // R12
  end

  // Transmit accept: a word is taken only into a free or draining hold slot
  assign tx_ready = ctrl_q[ebp_pkg::CTRL_TX_EN] && st_q == ebp_pkg::ebp_st_run
                    && (!hold_v_q || stg_in_ready); // R4
  assign acc      = tx_valid && tx_ready; // R24

  always_comb
  begin
    f      = tx_sop ? '0 : tx_data[ebp_pkg::SB_LSB +: ebp_pkg::SB_W]; // R7
    nb     = (tx_data[ebp_pkg::MOD_LSB +: ebp_pkg::MOD_W] == 5'h00) ? 7'h20
             : {2'b00, tx_data[ebp_pkg::MOD_LSB +: ebp_pkg::MOD_W]};
    end_i  = 7'h20 + nb;
    w0     = {tx_data[255:0], hold_q};
    idx_x  = {9'h000, f[ebp_pkg::FLG_OFF_LSB +: ebp_pkg::FLG_OFF_W]} + 17'h00020 - {1'b0, wpos_q}; // R21
    idx    = idx_x[6:0];
    // Field patched once, when all eight bytes sit in the held word of the two-word window
    hit    = acc && !tx_sop && f[ebp_pkg::FLG_UPD] && !done_q && !idx_x[16] && idx_x[15:0] <= 16'h0018
             && idx_x[15:0] + 16'h0008 <= 16'h0020 + {9'h000, nb}; // R18
    oldf   = get_field(w0, idx);
    corr_sum = oldf[63:16] + {18'h00000, now_lo - ts_in_q}
               + (f[ebp_pkg::FLG_PEER] ? {16'h0000, peer_q} : 48'h000000000000); // R19
    if (f[ebp_pkg::FLG_TS64])
      newf = now_q; // R22
    else if (f[ebp_pkg::FLG_DELTA])
      newf = {oldf[63:16] + tx_corr_delta, oldf[15:0]}; // R23
    else
      newf = {corr_sum, oldf[15:0]};
    w1     = hit ? put_field(w0, idx, newf) : w0;
    ins    = f[ebp_pkg::FLG_INS];
    ovr    = !ins && f[ebp_pkg::FLG_OVR]; // R16
    // Checksum bytes end before any check field already in the frame
    dend   = ins ? end_i : end_i - ebp_pkg::FCS_BYTES;
    pend   = udp_pend_q || (hit && f[ebp_pkg::FLG_UDP] && !f[ebp_pkg::FLG_TS64]);
    adj    = udp_pend_q ? udp_adj_q : oc_add(oc_sum3(oldf), ~oc_sum3(newf));
    w2     = w1;
    udp_v  = {w1[int'(dend - ebp_pkg::UDP_BYTES)*8 +: 8], w1[int'(dend - 7'h01)*8 +: 8]};
    if (tx_eop && pend)
    begin
      udp_v = oc_add(udp_v, adj); // R20
      w2[int'(dend - ebp_pkg::UDP_BYTES)*8 +: 8] = udp_v[15:8];
      w2[int'(dend - 7'h01)*8 +: 8]              = udp_v[7:0];
    end
    crc_next = crc_fold(tx_sop ? ebp_pkg::CRC_INIT : crc_q, w2, tx_sop ? 7'h20 : 7'h00,
                        !tx_eop ? 7'h20 : (ovr ? end_i - ebp_pkg::FCS_BYTES : end_i));
    fcs_good = ~crc_next ^ (f[ebp_pkg::FLG_INV] ? 32'hFFFFFFFF : 32'h00000000); // R15
    fcs_out  = fcs_good ^ (f[ebp_pkg::FLG_ERR] ? ebp_pkg::CRC_ERR_BIT : 32'h00000000); // R14
    w3       = w2;
    if (tx_eop && ovr)
      for (int k = 0; k < 4; k++)
        w3[(int'(end_i - ebp_pkg::FCS_BYTES) + k)*8 +: 8] = fcs_out[k*8 +: 8]; // R16
    else if (tx_eop && !ins && f[ebp_pkg::FLG_ERR])
      w3[int'(end_i - 7'h01)*8 +: 8] = w2[int'(end_i - 7'h01)*8 +: 8] ^ ebp_pkg::BYTE_ERR; // R14
  end

  // Hold slot: one word of look-ahead lets check bytes straddle words; fields are patched only within the held word
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_q     <= '0;
      hold_v_q   <= 1'b0;
      hold_sop_q <= 1'b0;
      hold_eop_q <= 1'b0;
      hold_mod_q <= '0;
      hold_app_q <= 1'b0;
      hold_fcs_q <= '0;
      hold_cls_q <= '0;
      hold_tag_q <= '0;
      st_q       <= ebp_pkg::ebp_st_run;
    end
    else if (acc)
    begin
      hold_q     <= w3[511:256];
      hold_v_q   <= 1'b1;
      hold_sop_q <= tx_sop; // R6
      hold_eop_q <= tx_eop;
      hold_mod_q <= tx_data[ebp_pkg::MOD_LSB +: ebp_pkg::MOD_W];
      hold_app_q <= tx_eop && ins; // R15
      hold_fcs_q <= fcs_out;
      hold_cls_q <= {f[ebp_pkg::FLG_EVENT], f[ebp_pkg::FLG_CLS_A], f[ebp_pkg::FLG_CLS_B]}; // R13
      hold_tag_q <= f[ebp_pkg::FLG_TAG_LSB +: ebp_pkg::FLG_TAG_W];
      if (tx_eop)
        st_q <= ebp_pkg::ebp_st_flush;
    end
    else if (st_q == ebp_pkg::ebp_st_flush && stg_in_ready)
    begin
      hold_v_q <= 1'b0;
      st_q     <= ebp_pkg::ebp_st_run;
    end
  end

  // Per-frame one-step and check state
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wpos_q     <= '0;
      crc_q      <= ebp_pkg::CRC_INIT;
      done_q     <= 1'b0;
      ts_in_q    <= '0;
      udp_pend_q <= 1'b0;
      udp_adj_q  <= '0;
    end
    else if (acc)
    begin
      wpos_q     <= tx_sop ? 16'h0020 : wpos_q + 16'h0020;
      crc_q      <= crc_next;
      done_q     <= !tx_sop && (done_q || hit);
      udp_pend_q <= !tx_sop && !tx_eop && pend;
      udp_adj_q  <= adj;
      if (tx_sop)
        ts_in_q <= tx_data[ebp_pkg::SB_LSB +: ebp_pkg::SB_W]; // R11
    end
  end

  assign stg_in_valid = hold_v_q && (acc || st_q == ebp_pkg::ebp_st_flush);

  ebp_stage #(
    .WIDTH (TXP_W)
  ) u_tx_stage (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (stg_in_valid),
    .in_ready  (stg_in_ready),
    .in_data   ({hold_sop_q, hold_eop_q, hold_mod_q, hold_app_q, hold_fcs_q, hold_cls_q, hold_tag_q,
                 (st_q == ebp_pkg::ebp_st_flush) ? hold_q : w3[255:0]}),
    .out_valid (line_tx_valid),
    .out_ready (line_tx_ready),
    .out_data  ({line_tx_sop, line_tx_eop, line_tx_mod, line_tx_fcs_append, line_tx_fcs, line_tx_event,
                 line_tx_class_a, line_tx_class_b, line_tx_tag, line_tx_data})
  );

  // Receive: start word sideband swapped for the local time
  assign line_rx_ready = ctrl_q[ebp_pkg::CTRL_RX_EN] && rx_in_ready; // R8

  ebp_stage #(
    .WIDTH (RXP_W + 2)
  ) u_rx_stage (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (line_rx_valid && ctrl_q[ebp_pkg::CTRL_RX_EN]),
    .in_ready  (rx_in_ready),
    .in_data   ({line_rx_sop, line_rx_eop, 2'b00, line_rx_sop ? now_lo : line_rx_flags,
                 line_rx_mod, line_rx_data}), // R10
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  ({rx_sop, rx_eop, rx_data})
  );

  // Transmit status and counters
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_status_valid <= 1'b0;
      tx_status_tag   <= '0;
      tx_cnt_q        <= '0;
      rx_cnt_q        <= '0;
    end
    else
    begin
      tx_status_valid <= line_tx_valid && line_tx_ready && line_tx_eop; // R17
      if (line_tx_valid && line_tx_ready && line_tx_eop)
      begin
        tx_status_tag <= line_tx_tag;
        tx_cnt_q      <= tx_cnt_q + 32'h00000001;
      end
      if (rx_valid && rx_ready && rx_eop)
        rx_cnt_q <= rx_cnt_q + 32'h00000001;
    end
  end

  // APB: zero wait states, error on unmapped offsets
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !apb_hit;
  assign apb_wr  = psel && penable && pwrite && apb_hit;

  always_comb
  begin
    rd_val  = '0;
    apb_hit = 1'b1;
    if (paddr == ebp_pkg::REG_CTRL)
      rd_val = {30'h00000000, ctrl_q};
    else if (paddr == ebp_pkg::REG_STAT)
      rd_val = {29'h00000000, dest_err_q, hold_v_q, st_q == ebp_pkg::ebp_st_flush};
    else if (paddr == ebp_pkg::REG_PEER)
      rd_val = peer_q;
    else if (paddr == ebp_pkg::REG_TXTAG)
      rd_val = {28'h0000000, tx_status_tag};
    else if (paddr == ebp_pkg::REG_TXCNT)
      rd_val = tx_cnt_q;
    else if (paddr == ebp_pkg::REG_RXCNT)
      rd_val = rx_cnt_q;
    else if (paddr == ebp_pkg::REG_TIME)
      rd_val = now_q[31:0];
    else
      apb_hit = 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= rd_val;
  end

  // Software state; a wrong destination sets a sticky bit, set beats clear
  always_ff @(posedge clock or negedge reset_n) // R2
  begin
    if (!reset_n)
    begin
      ctrl_q     <= ebp_pkg::CTRL_RESET;
      peer_q     <= '0;
      dest_err_q <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == ebp_pkg::REG_CTRL)
        ctrl_q <= pwdata[1:0];
      if (apb_wr && paddr == ebp_pkg::REG_PEER)
        peer_q <= pwdata;
      if (acc && tx_sop && tx_dest != ebp_pkg::UNIT_ID) // R5
        dest_err_q <= 1'b1;
      else if (apb_wr && paddr == ebp_pkg::REG_STAT && pwdata[ebp_pkg::STAT_DESTER])
        dest_err_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_rx_src_ones: assert property (rx_src == ebp_pkg::UNIT_ID && fabric_reset_n == 1'b0) // R9
    else $error("rx source id or fabric reset wrong");
  a_time_step: assert property ($past(reset_n) |-> now_q == $past(now_q) + ebp_pkg::TS_STEP) // R12
    else $error("timestamp counter did not step");
  a_rx_sop_stamp: assert property (line_rx_valid && line_rx_ready && line_rx_sop |=> // R10
    rx_valid && rx_sop && rx_data[ebp_pkg::SB_LSB +: ebp_pkg::SB_W] == $past(now_lo))
    else $error("receive start word lacks timestamp");
  a_line_hold: assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data)) // R24
    else $error("line word changed while stalled");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) // R24
    else $error("receive word changed while stalled");
  a_flush_busy: assert property (st_q == ebp_pkg::ebp_st_flush || !ctrl_q[ebp_pkg::CTRL_TX_EN] |-> !tx_ready) // R4
    else $error("tx ready while flushing or disabled");
  a_eop_flush: assert property (acc && tx_eop |=> st_q == ebp_pkg::ebp_st_flush ##1 hold_eop_q) // R4
    else $error("end word did not enter flush");
  a_fcs_append: assert property (acc && tx_eop && ins && !f[ebp_pkg::FLG_ERR] |=> // R15
    hold_app_q && hold_fcs_q == $past(fcs_good))
    else $error("appended check value wrong");
  a_fcs_error: assert property (acc && tx_eop && ins && f[ebp_pkg::FLG_ERR] |=> // R14
    hold_fcs_q == ($past(fcs_good) ^ ebp_pkg::CRC_ERR_BIT))
    else $error("forced error not applied");
  a_ovr_no_app: assert property (acc && tx_eop && !ins |=> !hold_app_q) // R16
    else $error("check appended without insert");
  a_upd_gate: assert property (acc && !f[ebp_pkg::FLG_UPD] |-> !hit) // R18
    else $error("field update without enable");
  a_status_tag: assert property (line_tx_valid && line_tx_ready && line_tx_eop |=> // R17
    tx_status_valid && tx_status_tag == $past(line_tx_tag))
    else $error("status tag not reported");

  c_append: cover property (acc && tx_eop && ins);
  c_patch: cover property (hit && f[ebp_pkg::FLG_TS64]);
  c_rx_sop: cover property (rx_valid && rx_ready && rx_sop);
  c_stall: cover property (st_q == ebp_pkg::ebp_st_flush && !stg_in_ready);

endmodule

// file: dv/ebp_mac_model.sv
`timescale 1ns/1ns
module ebp_mac_model
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Transmit from the port
  input  wire logic         line_tx_valid,
  output logic              line_tx_ready,
  input  wire logic [255:0] line_tx_data,
  input  wire logic         line_tx_eop,
  input  wire logic         line_tx_sop,
  input  wire logic         line_tx_fcs_append,
  input  wire logic         line_tx_class_a,
  output logic      [7:0]   tx_words,
  output logic      [2:0]   tx_last,
  output logic      [63:0]  tx_head,
  // Receive into the port
  input  wire logic         rx_go,
  output logic              line_rx_valid,
  input  wire logic         line_rx_ready,
  output logic      [255:0] line_rx_data,
  output logic      [4:0]   line_rx_mod,
  output logic              line_rx_sop,
  output logic              line_rx_eop,
  output logic      [29:0]  line_rx_flags
);
  logic [1:0] stall_q;
  logic [1:0] rx_cnt_q;
  // Stall one cycle in four so the port must hold its word
  assign line_tx_ready = (stall_q != 2'h3);
  assign line_rx_valid = (rx_cnt_q != 2'h0);
  assign line_rx_sop   = (rx_cnt_q == 2'h1);
  assign line_rx_eop   = (rx_cnt_q == 2'h2);
  // Idle lines show a changing pattern, never the old word
  assign line_rx_data  = line_rx_valid ? {254'h0, rx_cnt_q} : {128{stall_q}};
  assign line_rx_flags = line_rx_valid ? 30'h00000155 : {15{stall_q}};
  assign line_rx_mod   = line_rx_valid ? 5'h07 : {stall_q, stall_q, stall_q[0]};
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      stall_q  <= 2'h0;
      tx_words <= 8'h00;
      tx_last  <= 3'h0;
      tx_head  <= 64'h0000000000000000;
    end
    else
    begin
      stall_q <= stall_q + 2'h1;
      if (line_tx_valid && line_tx_ready)
      begin
        tx_words <= tx_words + 8'h01;
        if (line_tx_eop)
          tx_last <= {1'b1, line_tx_fcs_append, line_tx_class_a};
        // Bytes 16 to 23 of the first word, where a patched field sits
        if (line_tx_sop)
          tx_head <= line_tx_data[191:128];
      end
    end
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      rx_cnt_q <= 2'h0;
    else if (rx_cnt_q == 2'h0)
      rx_cnt_q <= rx_go ? 2'h1 : 2'h0;
    else if (line_rx_ready)
      rx_cnt_q <= (rx_cnt_q == 2'h2) ? 2'h0 : rx_cnt_q + 2'h1;
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_valid = 1'b0;
  logic tx_sop = 1'b0, tx_eop = 1'b0, rx_ready = 1'b0, rx_go = 1'b0, e;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, q;
  logic [3:0]   tx_dest = 4'hF;
  logic [292:0] tx_data = '0;
  logic [47:0]  tx_corr_delta = 48'h010203040506;
  logic fabric_reset_n, pready, pslverr, tx_ready, tx_status_valid, rx_valid, rx_sop, rx_eop;
  logic line_tx_valid, line_tx_ready, line_tx_sop, line_tx_eop, line_tx_fcs_append, line_tx_event;
  logic line_tx_class_a, line_tx_class_b, line_rx_valid, line_rx_ready, line_rx_sop, line_rx_eop;
  logic [3:0]   tx_status_tag, rx_src;
  logic [31:0]  prdata, line_tx_fcs;
  logic [292:0] rx_data;
  logic [255:0] line_tx_data, line_rx_data;
  logic [4:0]   line_tx_mod, line_rx_mod;
  logic [29:0]  line_rx_flags;
  logic [7:0]   tx_words;
  logic [2:0]   tx_last;
  logic [63:0]  tx_head;
  int fails = 0, checks = 0;
  ebp_port dut (.*);
  ebp_mac_model mac (.*);
  initial
    forever #5 clock = ~clock;
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bitwise reference check value, bit 0 of byte 0 first
  function automatic logic [31:0] crc_ref(input logic [767:0] b, input int n);
    logic [31:0] c;
    c = ebp_pkg::CRC_INIT;
    for (int i = 0; i < n * 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ ebp_pkg::CRC_POLY) : (c >> 1);
    return ~c;
  endfunction
  function automatic logic hi(input int w);
    return w == 0 ? pready : w == 1 ? tx_ready : w == 2 ? rx_valid : tx_status_valid;
  endfunction
  // Bounded wait, sampled mid-cycle where combinational answers have settled
  task automatic wait_for(input int w);
    int n;
    @(negedge clock);
    for (n = 0; hi(w) !== 1'b1; n++)
    begin
      if (n > 200)
      begin
        fails++;
        stop_test();
      end
      @(negedge clock);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    wait_for(0);
    @(posedge clock);
    e = pslverr;
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Words go back to back; valid drops only after the last handshake
  task automatic frame(input logic [29:0] fl, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      tx_valid <= 1'b1;
      tx_sop   <= (i == 0);
      tx_eop   <= (i == n - 1);
      tx_data  <= {2'h0, (i == 0) ? 30'h00001234 : fl, 5'h00, 256'(i + 1)};
      wait_for(1);
    end
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("fabric_reset_n", 64'(fabric_reset_n), 64'h0);
    chk("rx_src", 64'(rx_src), 64'hF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 64'(q), 64'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 64'({e, q}), 64'h100000000);
    apb(1'b1, 8'h00, 32'h2);
    @(negedge clock);
    chk("tx_ready off", 64'(tx_ready), 64'h0);
    apb(1'b1, 8'h00, 32'h3);
    $display("test registers done");
    frame(30'h0048000A, 3);
    wait_for(3);
    chk("tag", 64'(tx_status_tag), 64'hA);
    chk("insert class", 64'(tx_last), 64'h7);
    chk("fcs", 64'(line_tx_fcs), 64'(crc_ref({256'(3), 256'(2), 256'(1)}, 96)));
    chk("no patch", tx_head, 64'h0000000000000000);
    frame(30'h00010815, 2);
    wait_for(3);
    chk("tag2", 64'(tx_status_tag), 64'h5);
    chk("delta field", tx_head, 64'h0000060504030201);
    chk("pass", 64'(tx_last), 64'h4);
    chk("words", 64'(tx_words), 64'h5);
    $display("test transmit done");
    @(posedge clock);
    rx_go <= 1'b1;
    @(posedge clock);
    rx_go <= 1'b0;
    wait_for(2);
    chk("rx sop", 64'(rx_sop), 64'h1);
    chk("rx word", rx_data[63:0], 64'h1);
    repeat (2) @(negedge clock);
    chk("rx held", 64'({rx_valid, rx_data[7:0]}), 64'h101);
    @(posedge clock);
    rx_ready <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    chk("rx eop", 64'({rx_eop, rx_data[260:256]}), 64'h27);
    chk("rx flags", 64'(rx_data[290:261]), 64'h155);
    $display("test receive done");
    stop_test();
  end
endmodule
